// ===== verilog/sbrs_pkg.sv
// Purpose: constants for the bus request, error and snoop phase agent
// Assumes: one common bus clock, all bus signals active high here
// Notes: pin polarity inversion is done outside this block
package sbrs_pkg;
  localparam int SBRS_ADDR_W = 33;
  localparam int SBRS_CMD_W = 5;
  localparam int SBRS_APAR_W = 2;
  localparam int SBRS_QUEUE_DEPTH = 8;
  localparam int SBRS_CNT_W = 4;
  // snoop timing in bus clocks
  localparam int SBRS_SNOOP_AFTER_REQ = 4;
  localparam int SBRS_SNOOP_SPACING = 3;
  localparam int SBRS_STALL_EXTEND = 2;
  localparam logic [3:0] SBRS_TMR_ZERO = 4'h0;
  // snoop result encodings {shared, dirty}
  localparam logic [1:0] SBRS_RES_CLEAN = 2'h0;
  localparam logic [1:0] SBRS_RES_MOD = 2'h1;
  localparam logic [1:0] SBRS_RES_SHARED = 2'h2;
  localparam logic [1:0] SBRS_RES_STALL = 2'h3;
endpackage

// ===== verilog/sbrs_agent.sv
// Purpose: request, error and snoop phase logic of one bus agent
// Assumes: bus inputs come from pins and are synchronised here
// Notes: arbitration, response and data phases live elsewhere
`timescale 1ns/1ns
module sbrs_agent
  import sbrs_pkg::*;
#(
  parameter int QUEUE_DEPTH = SBRS_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power-on configuration
  input wire logic cfg_parity_check,
  input wire logic cfg_error_observe,
  // local request side
  input wire logic req_pending,
  input wire logic bus_owner,
  input wire logic req_stalled,
  input wire logic [SBRS_ADDR_W-1:0] req_addr,
  input wire logic [SBRS_CMD_W-1:0] req_cmd_a,
  input wire logic [SBRS_CMD_W-1:0] req_cmd_b,
  input wire logic req_atomic,
  input wire logic req_complete,
  output logic req_taken,
  // local snoop side
  input wire logic snp_hit,
  input wire logic snp_dirty,
  input wire logic snp_busy,
  input wire logic snp_postpone,
  output logic snp_valid,
  output logic [1:0] snp_result,
  output logic snp_postponed,
  output logic txn_cancel,
  // bus inputs
  input wire logic txn_strobe_in,
  input wire logic [SBRS_ADDR_W-1:0] addr_in,
  input wire logic [SBRS_CMD_W-1:0] cmd_in,
  input wire logic [SBRS_APAR_W-1:0] address_parity_in,
  input wire logic command_parity_in,
  input wire logic error_signal_in,
  input wire logic shared_flag_in,
  input wire logic line_dirty_flag_in,
  input wire logic commit_postpone_in,
  // bus outputs, oe low means driving
  output logic txn_strobe_out,
  output logic txn_strobe_oe_n,
  output logic [SBRS_ADDR_W-1:0] addr_out,
  output logic [SBRS_CMD_W-1:0] cmd_out,
  output logic [SBRS_APAR_W-1:0] address_parity_out,
  output logic command_parity_out,
  output logic req_oe_n,
  output logic atomic_hold_out,
  output logic error_signal_out,
  output logic error_oe_n,
  output logic shared_flag_out,
  output logic line_dirty_flag_out,
  output logic commit_postpone_out,
  output logic snoop_oe_n
);

  initial begin
    if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 15 || SBRS_STALL_EXTEND != 2) begin
      $error("sbrs_agent: QUEUE_DEPTH out of range");
    end
  end

  localparam logic [SBRS_CNT_W-1:0] DEPTH = SBRS_CNT_W'(QUEUE_DEPTH);
  // two sync clocks and two decode clocks already spent
  localparam logic [3:0] T_SNOOP = 4'(SBRS_SNOOP_AFTER_REQ - 4);
  localparam logic [3:0] T_SPACE = 4'(SBRS_SNOOP_SPACING);

  // even parity over address halves
  function automatic logic [1:0] addr_par(
    input logic [SBRS_ADDR_W-1:0] a
  );
    addr_par = {^a[SBRS_ADDR_W-1:17], ^a[16:0]};
  endfunction

  // parity over command and strobe
  function automatic logic cmd_par(input logic [SBRS_CMD_W-1:0] c);
    cmd_par = ^c ^ 1'b1;
  endfunction

  // two-stage synchronisers for all bus inputs
  localparam int SW = 1 + SBRS_ADDR_W + SBRS_CMD_W + SBRS_APAR_W + 5;
  logic [SW-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    sync1_q <= {txn_strobe_in, addr_in, cmd_in, address_parity_in,
                command_parity_in, error_signal_in, shared_flag_in,
                line_dirty_flag_in, commit_postpone_in};
    sync2_q <= sync1_q;
  end
  logic b_ads, b_rp, b_err, b_hit, b_line_dirty_flag, b_def;
  logic [SBRS_ADDR_W-1:0] b_addr;
  logic [SBRS_CMD_W-1:0] b_cmd;
  logic [SBRS_APAR_W-1:0] b_ap;
  assign {b_ads, b_addr, b_cmd, b_ap, b_rp, b_err, b_hit, b_line_dirty_flag,
          b_def} = sync2_q;

  // request phase: idle, first clock, second clock
  typedef enum logic [1:0] {SBRS_IDLE, SBRS_REQ_A, SBRS_REQ_B} sbrs_req_e;
  sbrs_req_e rq_q, rq_d;
  logic ads_prev_q, ads_prev_d;
  logic [SBRS_CNT_W-1:0] rcnt_q, rcnt_d, scnt_q, scnt_d;
  logic can_start;

  always_comb begin
    can_start = req_pending && bus_owner && (rcnt_q < DEPTH) &&
                !req_stalled && !ads_prev_q && !b_ads &&
                (rq_q == SBRS_IDLE);
  end

  // bus view of a new request and error phase
  logic new_req_q, new_req_d, chk2_q, chk2_d, perr_q, perr_d;
  logic err_seen;
  always_comb begin
    new_req_d = b_ads && !ads_prev_q;
    ads_prev_d = b_ads;
    perr_d = 1'b0;
    chk2_d = new_req_d;
    if (cfg_parity_check && (new_req_d || chk2_q)) begin
      if (addr_par(b_addr) != b_ap || cmd_par(b_cmd) != b_rp) begin
        perr_d = 1'b1;
      end
    end
    err_seen = cfg_error_observe && b_err;
  end

  // request sequencer and outstanding count
  always_comb begin
    rq_d = rq_q;
    rcnt_d = rcnt_q;
    case (rq_q)
      SBRS_IDLE: begin
        if (can_start) begin
          rq_d = SBRS_REQ_A;
        end
      end
      SBRS_REQ_A: rq_d = SBRS_REQ_B;
      SBRS_REQ_B: rq_d = SBRS_IDLE;
      default: rq_d = SBRS_IDLE;
    endcase
    if (new_req_q && !req_complete) begin
      rcnt_d = rcnt_q + 1'b1;
    end else if (!new_req_q && req_complete && rcnt_q != '0) begin
      rcnt_d = rcnt_q - 1'b1;
    end
    if (err_seen && rcnt_d != '0) begin
      rcnt_d = rcnt_d - 1'b1;
    end
  end

  // snoop phase timing: wait after request, spacing, stall
  logic [3:0] wait_q, wait_d, space_q, space_d;
  logic pend_q, pend_d, samp_q, samp_d, drv_q, drv_d, drv2_q, drv2_d;
  logic [1:0] res_d;
  logic valid_d, post_d;
  always_comb begin
    wait_d = wait_q;
    space_d = (space_q != SBRS_TMR_ZERO) ? space_q - 4'h1 : space_q;
    pend_d = pend_q;
    // sample once the drive has crossed the synchroniser
    samp_d = drv2_q;
    drv_d = 1'b0;
    drv2_d = drv_q;
    scnt_d = scnt_q;
    valid_d = 1'b0;
    res_d = snp_result;
    post_d = snp_postponed;
    if (wait_q != SBRS_TMR_ZERO) begin
      wait_d = wait_q - 4'h1;
    end
    if (new_req_d) begin
      scnt_d = scnt_q + 1'b1;
      pend_d = 1'b1;
      wait_d = T_SNOOP;
    end
    if (pend_q && wait_q == SBRS_TMR_ZERO && space_q == SBRS_TMR_ZERO &&
        !drv_q && !drv2_q && !samp_q) begin
      drv_d = 1'b1;
    end
    if (samp_q) begin
      if (b_hit && b_line_dirty_flag) begin
        drv2_d = 1'b1;
      end else begin
        valid_d = 1'b1;
        res_d = {b_hit, b_line_dirty_flag};
        post_d = b_def && !b_line_dirty_flag;
        space_d = T_SPACE - 4'h3;
        if (scnt_d != '0) begin
          scnt_d = scnt_d - 1'b1;
        end
        pend_d = scnt_d != '0;
      end
    end
  end

  // own snoop drive values
  logic [1:0] own_flags;
  always_comb begin
    if (snp_busy) begin
      own_flags = SBRS_RES_STALL;
    end else if (snp_dirty) begin
      own_flags = SBRS_RES_MOD;
    end else if (snp_hit) begin
      own_flags = SBRS_RES_SHARED;
    end else begin
      own_flags = SBRS_RES_CLEAN;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rq_q <= SBRS_IDLE;
      ads_prev_q <= 1'b0;
      new_req_q <= 1'b0;
      chk2_q <= 1'b0;
      perr_q <= 1'b0;
      rcnt_q <= '0;
      scnt_q <= '0;
      wait_q <= SBRS_TMR_ZERO;
      space_q <= SBRS_TMR_ZERO;
      pend_q <= 1'b0;
      samp_q <= 1'b0;
      drv_q <= 1'b0;
      drv2_q <= 1'b0;
    end else begin
      rq_q <= rq_d;
      ads_prev_q <= ads_prev_d;
      new_req_q <= new_req_d;
      chk2_q <= chk2_d;
      perr_q <= perr_d;
      rcnt_q <= rcnt_d;
      scnt_q <= scnt_d;
      wait_q <= wait_d;
      space_q <= space_d;
      pend_q <= err_seen ? 1'b0 : pend_d;
      samp_q <= err_seen ? 1'b0 : samp_d;
      drv_q <= err_seen ? 1'b0 : drv_d;
      drv2_q <= err_seen ? 1'b0 : drv2_d;
    end
  end

  // output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      req_taken <= 1'b0;
      txn_strobe_out <= 1'b0;
      txn_strobe_oe_n <= 1'b1;
      addr_out <= '0;
      cmd_out <= '0;
      address_parity_out <= '0;
      command_parity_out <= 1'b0;
      req_oe_n <= 1'b1;
      atomic_hold_out <= 1'b0;
      error_signal_out <= 1'b0;
      error_oe_n <= 1'b1;
      shared_flag_out <= 1'b0;
      line_dirty_flag_out <= 1'b0;
      commit_postpone_out <= 1'b0;
      snoop_oe_n <= 1'b1;
      snp_valid <= 1'b0;
      snp_result <= SBRS_RES_CLEAN;
      snp_postponed <= 1'b0;
      txn_cancel <= 1'b0;
    end else begin
      req_taken <= rq_d == SBRS_REQ_A;
      txn_strobe_out <= rq_d == SBRS_REQ_A;
      txn_strobe_oe_n <= rq_d == SBRS_IDLE;
      req_oe_n <= rq_d == SBRS_IDLE;
      // address and its parity held through the second clock
      if (rq_d != SBRS_REQ_B) begin
        addr_out <= req_addr;
        address_parity_out <= addr_par(req_addr);
      end
      cmd_out <= (rq_d == SBRS_REQ_B) ? req_cmd_b : req_cmd_a;
      command_parity_out <= cmd_par((rq_d == SBRS_REQ_B) ?
                                    req_cmd_b : req_cmd_a);
      atomic_hold_out <= (rq_d == SBRS_REQ_A) && req_atomic;
      error_signal_out <= perr_q;
      error_oe_n <= !perr_q;
      shared_flag_out <= drv_d && own_flags[1];
      line_dirty_flag_out <= drv_d && own_flags[0];
      commit_postpone_out <= drv_d && snp_postpone;
      snoop_oe_n <= !drv_d;
      snp_valid <= valid_d;
      snp_result <= res_d;
      snp_postponed <= post_d;
      txn_cancel <= err_seen;
    end
  end

endmodule

// ===== test/sbrs_agent_chk.sv
// Purpose: port checks for the bus phase agent
// Assumes: one clock, sync reset, bound to the agent
// Notes: own-count helper undercounts foreign traffic on purpose
`timescale 1ns/1ns
module sbrs_agent_chk
  import sbrs_pkg::*;
#(
  parameter int QUEUE_DEPTH = SBRS_QUEUE_DEPTH
) (
  // clock, config, local side
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_parity_check,
  input wire logic cfg_error_observe,
  input wire logic req_pending,
  input wire logic bus_owner,
  input wire logic req_stalled,
  input wire logic [SBRS_ADDR_W-1:0] req_addr,
  input wire logic req_atomic,
  input wire logic req_complete,
  input wire logic req_taken,
  input wire logic snp_valid,
  input wire logic [1:0] snp_result,
  input wire logic txn_cancel,
  // bus outputs
  input wire logic txn_strobe_out,
  input wire logic [SBRS_ADDR_W-1:0] addr_out,
  input wire logic [SBRS_CMD_W-1:0] cmd_out,
  input wire logic command_parity_out,
  input wire logic req_oe_n,
  input wire logic atomic_hold_out,
  input wire logic error_signal_out,
  input wire logic error_oe_n
);
  logic [SBRS_CNT_W-1:0] own_q, own_d;
  // own transactions still open
  always_comb begin
    own_d = own_q + SBRS_CNT_W'(txn_strobe_out);
    if (req_complete && own_d != '0) own_d = own_d - 1'b1;
    if (txn_cancel) own_d = '0;
  end
  always_ff @(posedge clk) own_q <= rst ? '0 : own_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_strobe_single: assert property (txn_strobe_out |=> !txn_strobe_out)
    else $error("strobe too long");
  a_start_qual: assert property (txn_strobe_out |->
    $past(req_pending && bus_owner && !req_stalled))
    else $error("start without qualifiers");
  a_taken_strobe: assert property (req_taken |-> txn_strobe_out && !req_oe_n)
    else $error("taken without strobe");
  a_addr_two: assert property (txn_strobe_out |->
    !req_oe_n && addr_out == $past(req_addr) ##1
    !req_oe_n && addr_out == $past(req_addr, 2))
    else $error("address not held");
  a_atomic_first: assert property (txn_strobe_out |->
    atomic_hold_out == $past(req_atomic))
    else $error("atomic hold wrong");
  a_cmd_parity: assert property (!req_oe_n |->
    command_parity_out == ~^cmd_out)
    else $error("command parity wrong");
  a_queue_limit: assert property (own_q <= SBRS_CNT_W'(QUEUE_DEPTH))
    else $error("queue overrun");
  a_error_gate: assert property (error_signal_out |->
    !error_oe_n && $past(cfg_parity_check))
    else $error("error without check");
  a_cancel_gate: assert property (txn_cancel |->
    $past(cfg_error_observe))
    else $error("cancel without observe");
  a_result_final: assert property (snp_valid |->
    snp_result != SBRS_RES_STALL)
    else $error("stall given as result");
endmodule
bind sbrs_agent sbrs_agent_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (.*);

// ===== test/sbrs_bus_model.sv
// Purpose: other agents issuing requests and snoop answers
// Assumes: lines pulled to inactive 0 when released
// Notes: one request per go pulse, answer chosen by mode
`timescale 1ns/1ns
module sbrs_bus_model
  import sbrs_pkg::*;
(
  // bench commands
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic bad_par,
  input wire logic [1:0] mode,
  input wire logic [SBRS_ADDR_W-1:0] addr,
  // bus drive
  output logic strobe,
  output logic [SBRS_ADDR_W-1:0] a_o,
  output logic [SBRS_CMD_W-1:0] cmd,
  output logic [SBRS_APAR_W-1:0] apar,
  output logic cpar,
  output logic shared,
  output logic dirty,
  output logic postpone
);
  logic [1:0] ph;
  logic [3:0] t;
  logic drv;
  // request step and snoop clock count
  always @(posedge clk) begin
    if (rst) begin
      ph <= 2'd0;
      t <= 4'd0;
    end else begin
      ph <= (ph == 2'd0) ? {1'b0, go} : ph + 2'd1;
      t <= (go && ph == 2'd0) ? 4'd1 :
        (t != 4'd0 && t < 4'd8) ? t + 4'd1 : 4'd0;
    end
  end
  assign strobe = ph == 2'd1;
  assign drv = ph == 2'd1 || ph == 2'd2;
  assign a_o = drv ? addr : '0;
  assign cmd = strobe ? 5'h06 : drv ? 5'h01 : 5'h00; // arbitrary codes
  assign apar = drv ? {^addr[32:17], ^addr[16:0]} ^ {2{bad_par}} : 2'h0;
  assign cpar = drv & (~^cmd ^ bad_par);
  assign shared = t == 4'd5 && mode[1];
  assign dirty = t == 4'd5 && mode[0];
  assign postpone = t == 4'd5 && mode == 2'd3;
endmodule

// ===== test/sbrs_agent_tb.sv
// Purpose: random and corner bench for the bus phase agent
// Assumes: 50 MHz clock, sync reset, inputs moved at falling edge
// Notes: queue depth cut to 2 to reach the full case
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: compare", $time); end end
module sbrs_agent_tb;
  import sbrs_pkg::*;
  logic clk = 0, rst = 1, cfg_parity_check = 0, cfg_error_observe = 0;
  logic req_pending = 0, bus_owner = 0, req_stalled = 0, req_atomic = 0;
  logic req_complete = 0, snp_hit = 0, snp_dirty = 0, snp_busy = 0;
  logic snp_postpone = 0, go = 0, bad_par = 0, seen;
  logic [1:0] mode = '0, snp_result;
  logic [SBRS_ADDR_W-1:0] req_addr = '0, m_addr = '0, addr_in, addr_out, m_a;
  logic [SBRS_CMD_W-1:0] req_cmd_a = '0, req_cmd_b = '0, cmd_in, cmd_out;
  logic [SBRS_CMD_W-1:0] m_cmd;
  logic [SBRS_APAR_W-1:0] address_parity_in, address_parity_out, m_ap;
  logic req_taken, snp_valid, snp_postponed, txn_cancel, txn_strobe_in;
  logic txn_strobe_out, txn_strobe_oe_n, command_parity_in, command_parity_out;
  logic req_oe_n, atomic_hold_out, error_signal_in, error_signal_out;
  logic error_oe_n, shared_flag_in, shared_flag_out, line_dirty_flag_in;
  logic line_dirty_flag_out, commit_postpone_in, commit_postpone_out;
  logic snoop_oe_n, m_stb, m_cp, m_sh, m_dt, m_pp;
  int checked = 0, bad_count = 0;
  always #10 clk = ~clk;
  // shared bus lines, inactive 0 when nobody drives
  assign txn_strobe_in = (!txn_strobe_oe_n & txn_strobe_out) | m_stb;
  assign addr_in = !req_oe_n ? addr_out : m_a;
  assign cmd_in = !req_oe_n ? cmd_out : m_cmd;
  assign address_parity_in = !req_oe_n ? address_parity_out : m_ap;
  assign command_parity_in = !req_oe_n ? command_parity_out : m_cp;
  assign error_signal_in = !error_oe_n & error_signal_out;
  assign shared_flag_in = (!snoop_oe_n & shared_flag_out) | m_sh;
  assign line_dirty_flag_in = (!snoop_oe_n & line_dirty_flag_out) | m_dt;
  assign commit_postpone_in = (!snoop_oe_n & commit_postpone_out) | m_pp;
  sbrs_agent #(.QUEUE_DEPTH(2)) DUT (.*);
  sbrs_bus_model model (.clk(clk), .rst(rst), .go(go), .bad_par(bad_par),
    .mode(mode), .addr(m_addr), .strobe(m_stb), .a_o(m_a), .cmd(m_cmd),
    .apar(m_ap), .cpar(m_cp), .shared(m_sh), .dirty(m_dt), .postpone(m_pp));
  // wait a bounded time for a pulse
  task automatic await(ref logic s);
    seen = 0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(negedge clk);
      seen = (s === 1'b1);
    end
  endtask
  // offer one request with random contents
  task automatic request(logic want);
    req_addr = {1'($urandom), $urandom};
    req_cmd_a = 5'($urandom);
    req_cmd_b = 5'($urandom);
    req_atomic = 1'($urandom);
    req_pending = 1;
    await(req_taken);
    req_pending = 0;
    `CHK(seen, want)
    if (seen) begin
      `CHK(cmd_out, req_cmd_a)
      @(negedge clk);
      `CHK(cmd_out, req_cmd_b)
      `CHK(txn_strobe_out, 1'b0)
    end
    repeat (12) @(negedge clk);
  endtask
  // foreign request, then the agent's snoop result
  task automatic snoop(logic [1:0] m);
    mode = m;
    m_addr = {1'($urandom), $urandom};
    go = 1;
    @(negedge clk);
    go = 0;
    await(snp_valid);
    `CHK(seen, 1'b1)
    `CHK(snp_result, m == 2'd3 ? SBRS_RES_CLEAN : m)
    `CHK(snp_postponed, 1'b0)
    repeat (12) @(negedge clk);
  endtask
  task automatic complete;
    req_complete = 1;
    @(negedge clk);
    req_complete = 0;
  endtask
  task automatic final_report;
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // span far beyond all tests
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'h3e122ed3));
    repeat (5) @(negedge clk);
    rst = 0;
    bus_owner = 1;
    for (int n = 0; n < 12; n++) begin
      request(1);
      complete();
    end
    $display("done: random requests");
    for (int k = 0; k < 2; k++) begin
      req_stalled = k[0];
      bus_owner = k[0];
      request(0);
    end
    req_stalled = 0;
    bus_owner = 1;
    $display("done: refusals");
    request(1);
    request(1);
    request(0);
    complete();
    request(1);
    complete();
    complete();
    $display("done: queue full");
    bus_owner = 0;
    for (int k = 0; k < 4; k++) begin
      snoop(k[1:0]);
      complete();
    end
    $display("done: snoop results");
    cfg_parity_check = 1;
    cfg_error_observe = 1;
    bad_par = 1;
    go = 1;
    @(negedge clk);
    go = 0;
    await(txn_cancel);
    `CHK(seen, 1'b1)
    $display("done: parity error");
    final_report();
  end
endmodule
